// ===== rtl/acr_pkg.sv
// Contract
// R1 - Overflow interrupt needs its enable and global enable
// R2 - Time-overflow interrupt needs its enable and global enable
// R3 - Writing start one begins conversion, zero nothing
// R4 - Start and enable accepted together in one write
// R5 - Software start bit clears itself automatically
// R6 - Busy reads one while any operation active
// R7 - Pulse mode selects timer, else direct input
// R8 - Invert bit inverts the selected sample input
// R9 - Locked configuration fields ignore writes while enabled
// R10 - Converter clock is source divided by field+1
package acr_pkg;

  // Register indices on the plain register port.
  localparam logic [3:0] ACR_ADDR_CTL0 = 4'h0;
  localparam logic [3:0] ACR_ADDR_CTL1 = 4'h1;

  // Values after reset.
  localparam logic [15:0] ACR_CTL0_RST = 16'h0000;
  localparam logic [15:0] ACR_CTL1_RST = 16'h0000;

  // Bit positions in control register 0.
  localparam int ACR_BIT_OVF_IE = 3;
  localparam int ACR_BIT_TOV_IE = 2;
  localparam int ACR_BIT_ENC = 1;
  localparam int ACR_BIT_SC = 0;

  // Bits of control register 0 that may change only while disabled.
  localparam logic [15:0] ACR_CTL0_LOCK_MASK = 16'hFFF0;

  // Trigger source code that selects the software start bit.
  localparam logic [1:0] ACR_TRIG_SOFTWARE = 2'h0;

  // Converter clock ticks spent in the timed sample phase.
  localparam logic [3:0] ACR_SAMPLE_TICKS = 4'h4;
  // Converter clock ticks spent converting.
  localparam logic [3:0] ACR_CONV_TICKS = 4'hD;

  // Layout of control register 1; bit 0 is the read-only busy flag.
  typedef struct packed {
    logic [3:0] sequence_start_address;
    logic [1:0] trigger_source_select;
    logic pulse_sample_mode;
    logic invert_sample_input;
    logic [2:0] conv_clock_divider;
    logic [1:0] conv_clock_source_select;
    logic [1:0] sequence_mode;
  } acr_ctl1_type;

  // Register port request.
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } acr_req_type;

endpackage

// ===== rtl/acr_clk_div.sv
`timescale 1ns/1ps
`default_nettype none
// Divides the selected source tick stream by the divider value plus one.
module acr_clk_div #(
  parameter int DIV_W = 3
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_src_tick,
  input wire logic [DIV_W-1:0] i_div,
  output logic o_tick
);

  // Count of source ticks seen in the current period.
  logic [DIV_W-1:0] cnt_ff;
  logic [DIV_W-1:0] nxt_cnt;
  // Registered divided tick.
  logic tick_ff;
  logic nxt_tick;

  // Count source ticks and emit one tick per div+1 of them.
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_tick = 1'b0;
    if (i_src_tick) begin
      // R10 - divide by field+1
      if (cnt_ff >= i_div) begin
        nxt_cnt = '0;
        nxt_tick = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + DIV_W'(1);
      end
    end
  end

  // Register the counter and the tick.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign o_tick = tick_ff;

endmodule
`default_nettype wire

// ===== rtl/acr_top.sv
`timescale 1ns/1ps
`default_nettype none
// Control registers and sample/convert sequencing of the converter.
module acr_top (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_global_irq_enable,
  input wire logic i_sample_input,
  input wire logic [3:0] i_clk_src_tick,
  input wire logic i_result_overflow_event,
  input wire logic i_conv_time_overflow_event,
  output logic [15:0] o_rdata,
  output logic o_converter_busy,
  output logic o_sampling_signal,
  output logic o_conv_clk_tick,
  output logic o_result_overflow_irq,
  output logic o_conv_time_overflow_irq
);

  // States of the sample and conversion sequencer.
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SAMPLE,
    ST_CONVERT
  } acr_state_type;

  // Request bundle gathered from the register port.
  acr_pkg::acr_req_type req;

  // Control register 0 and its next value.
  logic [15:0] ctl0_ff;
  logic [15:0] nxt_ctl0;
  // Control register 1 fields and their next value.
  acr_pkg::acr_ctl1_type ctl1_ff;
  acr_pkg::acr_ctl1_type nxt_ctl1;
  // Registered read data.
  logic [15:0] rdata_ff;
  logic [15:0] nxt_rdata;

  // Two-stage synchroniser for the external sample input.
  logic samp_meta_ff;
  logic samp_sync_ff;

  // Selected and possibly inverted sample-input signal.
  logic sel_sig;
  // Previous value of the selected signal for edge detection.
  logic sel_prev_ff;
  // Rising edge of the selected signal.
  logic sel_rise;

  // Sequencer state, tick counter and registered outputs.
  acr_state_type state_ff;
  acr_state_type nxt_state;
  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  logic busy_ff;
  logic nxt_busy;
  logic sampling_ff;
  logic nxt_sampling;

  // Registered interrupt requests.
  logic ovf_irq_ff;
  logic nxt_ovf_irq;
  logic tov_irq_ff;
  logic nxt_tov_irq;

  // Selected source tick and divided converter clock tick.
  logic src_tick;
  logic conv_tick;

  // Convenience views of control register 0.
  logic conversion_enable;
  logic sc;

  // Gather the register port into one request bundle.
  assign req.addr = i_addr;
  assign req.wdata = i_wdata;
  assign req.wr = i_wr;
  assign req.rd = i_rd;

  // The enable and start bits feed the sequencer directly.
  assign conversion_enable = ctl0_ff[acr_pkg::ACR_BIT_ENC];
  assign sc = ctl0_ff[acr_pkg::ACR_BIT_SC];

  // Pick the converter source clock tick chosen by the select field.
  // Each source arrives as a one-cycle tick enable on the core clock.
  assign src_tick = i_clk_src_tick[ctl1_ff.conv_clock_source_select];

  // Divider that produces the converter clock tick.
  acr_clk_div #(
    .DIV_W(3)
  ) u_clk_div (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_src_tick(src_tick),
    .i_div(ctl1_ff.conv_clock_divider),
    .o_tick(conv_tick)
  );

  // Synchronise the external sample input to the core clock.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      samp_meta_ff <= 1'b0;
      samp_sync_ff <= 1'b0;
    end else begin
      // Only the second stage feeds logic; the first may be metastable.
      samp_meta_ff <= i_sample_input;
      samp_sync_ff <= samp_meta_ff;
    end
  end

  // Choose the sample-input signal and apply the optional inversion.
  always_comb begin
    if (ctl1_ff.trigger_source_select == acr_pkg::ACR_TRIG_SOFTWARE) begin
      // The software start bit acts as the sample input.
      sel_sig = sc;
    end else begin
      // Any other source arrives on the synchronised pin.
      sel_sig = samp_sync_ff;
    end
    // R8 - invert sample input
    sel_sig = sel_sig ^ ctl1_ff.invert_sample_input;
  end

  // Starts need a rising edge, so a level held high starts only once.
  assign sel_rise = sel_sig & ~sel_prev_ff;

  // Compute register contents after a write from the register port.
  always_comb begin
    nxt_ctl0 = ctl0_ff;
    nxt_ctl1 = ctl1_ff;
    // R5 - start bit self-clears
    nxt_ctl0[acr_pkg::ACR_BIT_SC] = 1'b0;
    // A write to control register 0 always reaches bits 3 to 0.
    if (req.wr && req.addr == acr_pkg::ACR_ADDR_CTL0) begin
      if (conversion_enable) begin
        // R9 - locked bits kept
        nxt_ctl0 = (ctl0_ff & acr_pkg::ACR_CTL0_LOCK_MASK) |
                   (req.wdata & ~acr_pkg::ACR_CTL0_LOCK_MASK);
      end else begin
        // R4 - enable and start together
        nxt_ctl0 = req.wdata;
      end
      // R3 - one starts, zero nothing
      nxt_ctl0[acr_pkg::ACR_BIT_SC] = req.wdata[acr_pkg::ACR_BIT_SC];
    end
    // R9 - ignore while enabled
    if (req.wr && req.addr == acr_pkg::ACR_ADDR_CTL1 && !conversion_enable) begin
      // Written bit 0 lands on the read-only busy flag and is dropped.
      nxt_ctl1 = acr_pkg::acr_ctl1_type'(req.wdata[15:1]);
    end
  end

  // Compute read data for the cycle after a read strobe.
  always_comb begin
    nxt_rdata = 16'h0000;
    // Read data stays zero unless a read strobe is seen.
    if (req.rd) begin
      case (req.addr)
        acr_pkg::ACR_ADDR_CTL0: begin
          // Control register 0 reads back as stored.
          nxt_rdata = ctl0_ff;
        end
        acr_pkg::ACR_ADDR_CTL1: begin
          // R6 - busy in bit 0
          nxt_rdata = {ctl1_ff, state_ff != ST_IDLE};
        end
        default: begin
          // Unmapped addresses read as zero.
          nxt_rdata = 16'h0000;
        end
      endcase
    end
  end

  // Register the control registers and the read data.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ctl0_ff <= acr_pkg::ACR_CTL0_RST;
      ctl1_ff <= acr_pkg::acr_ctl1_type'(acr_pkg::ACR_CTL1_RST[15:1]);
      // Read data idles at zero between reads.
      rdata_ff <= 16'h0000;
    end else begin
      ctl0_ff <= nxt_ctl0;
      ctl1_ff <= nxt_ctl1;
      rdata_ff <= nxt_rdata;
    end
  end

  // Sequence one sample phase and one conversion phase per trigger.
  // Clearing the enable bit mid-run does not abort a run in progress.
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_sampling = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        // A rising trigger edge starts only while conversion is enabled.
        if (conversion_enable && sel_rise) begin
          nxt_state = ST_SAMPLE;
          nxt_cnt = 4'h0;
          nxt_sampling = 1'b1;
        end
      end
      // Further triggers are ignored until the run is over.
      ST_SAMPLE: begin
        nxt_sampling = 1'b1;
        // R7 - timer or direct
        if (ctl1_ff.pulse_sample_mode) begin
          // The sampling timer holds for a fixed number of ticks.
          if (conv_tick) begin
            if (cnt_ff + 4'h1 >= acr_pkg::ACR_SAMPLE_TICKS) begin
              // The timer has run out; conversion starts.
              nxt_state = ST_CONVERT;
              nxt_cnt = 4'h0;
              nxt_sampling = 1'b0;
            end else begin
              // Count one more timer tick.
              nxt_cnt = cnt_ff + 4'h1;
            end
          end
        end else if (!sel_sig) begin
          // The sample input itself ends the sample phase.
          nxt_state = ST_CONVERT;
          nxt_cnt = 4'h0;
          nxt_sampling = 1'b0;
        end
      end
      ST_CONVERT: begin
        // Conversion lasts a fixed number of converter clock ticks.
        if (conv_tick) begin
          if (cnt_ff + 4'h1 >= acr_pkg::ACR_CONV_TICKS) begin
            // The last tick ends the run; busy drops on the next edge.
            nxt_state = ST_IDLE;
            nxt_cnt = 4'h0;
          end else begin
            // Count one more converter tick.
            nxt_cnt = cnt_ff + 4'h1;
          end
        end
      end
      default: begin
        // Recover from an illegal state.
        nxt_state = ST_IDLE;
        nxt_cnt = 4'h0;
      end
    endcase
    // R6 - busy while active
    nxt_busy = nxt_state != ST_IDLE;
  end

  // Register the sequencer state and its outputs.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 4'h0;
      busy_ff <= 1'b0;
      sampling_ff <= 1'b0;
      // The edge detector starts low, the idle level of the start bit.
      sel_prev_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      busy_ff <= nxt_busy;
      sampling_ff <= nxt_sampling;
      sel_prev_ff <= sel_sig;
    end
  end

  // Gate converter events with their enables and the global enable.
  // The requests are plain gated pulses; nothing latches them.
  always_comb begin
    // R1 - overflow needs both enables
    nxt_ovf_irq = i_result_overflow_event &
                  ctl0_ff[acr_pkg::ACR_BIT_OVF_IE] & i_global_irq_enable;
    // R2 - time overflow needs both
    nxt_tov_irq = i_conv_time_overflow_event &
                  ctl0_ff[acr_pkg::ACR_BIT_TOV_IE] & i_global_irq_enable;
  end

  // Register the interrupt requests.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      // No request is pending after reset.
      ovf_irq_ff <= 1'b0;
      tov_irq_ff <= 1'b0;
    end else begin
      ovf_irq_ff <= nxt_ovf_irq;
      tov_irq_ff <= nxt_tov_irq;
    end
  end

  // Every output is taken straight from a register.
  assign o_rdata = rdata_ff;
  assign o_converter_busy = busy_ff;
  assign o_sampling_signal = sampling_ff;
  assign o_conv_clk_tick = conv_tick;
  assign o_result_overflow_irq = ovf_irq_ff;
  assign o_conv_time_overflow_irq = tov_irq_ff;

endmodule
`default_nettype wire

// ===== verification/acr_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// Timing relations between the converter control ports.
module acr_top_monitor (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_global_irq_enable,
  input wire logic i_sample_input,
  input wire logic [3:0] i_clk_src_tick,
  input wire logic i_result_overflow_event,
  input wire logic i_conv_time_overflow_event,
  input wire logic [15:0] o_rdata,
  input wire logic o_converter_busy,
  input wire logic o_sampling_signal,
  input wire logic o_conv_clk_tick,
  input wire logic o_result_overflow_irq,
  input wire logic o_conv_time_overflow_irq
);
  default clocking dc @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);
  property p_ovf;
    o_result_overflow_irq |->
      $past(i_result_overflow_event && i_global_irq_enable);
  endproperty
  a_ovf: assert property (p_ovf) else $error("stray overflow irq");
  property p_tov;
    o_conv_time_overflow_irq |->
      $past(i_conv_time_overflow_event && i_global_irq_enable);
  endproperty
  a_tov: assert property (p_tov) else $error("stray time irq");
  property p_rdz;
    !$past(i_rd) |-> o_rdata == 16'h0000;
  endproperty
  a_rdz: assert property (p_rdz) else $error("read data leaks");
  property p_samp_busy;
    o_sampling_signal |-> o_converter_busy;
  endproperty
  a_samp_busy: assert property (p_samp_busy) else $error("idle sample");
  property p_busy_min;
    $rose(o_converter_busy) |-> o_converter_busy[*8];
  endproperty
  a_busy_min: assert property (p_busy_min) else $error("busy short");
  property p_busy_end;
    $fell(o_converter_busy) |->
      $past(o_conv_clk_tick) || $past(o_conv_clk_tick, 2);
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("busy end");
  property p_samp_rise;
    $rose(o_sampling_signal) |-> $rose(o_converter_busy);
  endproperty
  a_samp_rise: assert property (p_samp_rise) else $error("sample");
  property p_tick_src;
    o_conv_clk_tick |->
      $past(|i_clk_src_tick) || $past(|i_clk_src_tick, 2);
  endproperty
  a_tick_src: assert property (p_tick_src) else $error("tick");
  c_busy: cover property ($rose(o_converter_busy));
  c_irq: cover property (o_result_overflow_irq);
  c_samp: cover property ($fell(o_sampling_signal) && o_converter_busy);
endmodule
bind acr_top acr_top_monitor acr_top_monitor_inst (.*);
`default_nettype wire

// ===== verification/test_acr_top.sv
`timescale 1ns/1ps
`default_nettype none
// Register level checks of the converter control block.
module test_acr_top;
  logic i_core_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0;
  logic i_global_irq_enable = 0, i_sample_input = 1;
  logic i_result_overflow_event = 0, i_conv_time_overflow_event = 0;
  logic [3:0] i_addr = 4'h0, i_clk_src_tick = 4'hF;
  logic [15:0] i_wdata = 16'h0000, o_rdata;
  logic o_converter_busy, o_sampling_signal, o_conv_clk_tick;
  logic o_result_overflow_irq, o_conv_time_overflow_irq;
  int num_errors = 0, compares = 0, n;
  acr_top acr_top_inst (.*);
  always #50 i_core_clk = ~i_core_clk;
  // Counts a comparison and reports a mismatch.
  task chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_core_clk);
    i_wr <= 1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_core_clk);
    i_wr <= 0;
  endtask
  task rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge i_core_clk);
    i_rd <= 1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 0;
    #1;
    chk(o_rdata, e);
  endtask
  function automatic logic sg(int s);
    return s == 0 ? o_converter_busy : s == 1 ? o_sampling_signal
      : o_conv_clk_tick;
  endfunction
  // Waits a bounded time for a port to reach a level; n counts cycles.
  task wt(input int s, input logic v, output int c);
    c = 0;
    while (sg(s) !== v) begin
      @(posedge i_core_clk);
      #1;
      c++;
      if (c > 300) begin
        num_errors++;
        close_out();
      end
    end
  endtask
  task close_out();
    if (num_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge i_core_clk);
    i_rst <= 0;
    rd(4'h0, 16'h0000);
    rd(4'h1, 16'h0000);
    wr(4'h5, 16'hFFFF);
    rd(4'h5, 16'h0000);
    for (int d = 0; d < 8; d++) begin
      wr(4'h1, 16'(d << 5));
      repeat (10) @(posedge i_core_clk);
      #1;
      wt(2, 1, n);
      @(posedge i_core_clk);
      #1;
      wt(2, 1, n);
      chk(16'(n), 16'(d));
    end
    for (int s = 0; s < 4; s++) begin
      wr(4'h1, 16'(s << 3));
      i_clk_src_tick <= 4'h4;
      repeat (3) @(posedge i_core_clk);
      #1;
      chk(o_conv_clk_tick, 16'(s == 2));
    end
    @(posedge i_core_clk);
    i_clk_src_tick <= 4'hF;
    wr(4'h1, 16'h0240);
    wr(4'h0, 16'h0002);
    repeat (5) @(posedge i_core_clk);
    #1;
    chk(o_converter_busy, 0);
    wr(4'h1, 16'h0000);
    rd(4'h1, 16'h0240);
    wr(4'h0, 16'hA002);
    rd(4'h0, 16'h0002);
    wr(4'h0, 16'h0003);
    #1;
    wt(0, 1, n);
    chk(n < 4, 1);
    wt(1, 0, n);
    chk(n > 8 && n < 16, 1);
    rd(4'h1, 16'h0241);
    rd(4'h0, 16'h0002);
    wt(0, 0, n);
    rd(4'h1, 16'h0240);
    wr(4'h0, 16'h0000);
    wr(4'h1, 16'h0500);
    wr(4'h0, 16'h0002);
    i_sample_input <= 0;
    #1;
    wt(1, 1, n);
    chk(n < 6, 1);
    repeat (10) @(posedge i_core_clk);
    i_sample_input <= 1;
    #1;
    chk(o_sampling_signal, 1);
    wt(1, 0, n);
    chk(n < 6, 1);
    wt(0, 0, n);
    for (int k = 0; k < 8; k++) begin
      wr(4'h0, {12'h000, k[1:0], 2'b00});
      i_global_irq_enable <= k[2];
      @(posedge i_core_clk);
      i_result_overflow_event <= 1;
      i_conv_time_overflow_event <= 1;
      @(posedge i_core_clk);
      i_result_overflow_event <= 0;
      i_conv_time_overflow_event <= 0;
      #1;
      chk(o_result_overflow_irq, k[1] & k[2]);
      chk(o_conv_time_overflow_irq, k[0] & k[2]);
    end
    close_out();
  end
endmodule
`default_nettype wire
